//--- src/cap_desc_parser.sv
/*
 Byte-serial parser for capability and icon descriptors.
 Assumes an upstream demultiplexer giving one byte per valid cycle,
 each descriptor starting with its tag byte; no back-pressure.
*/
// What this block does
// - Capability descriptor recognised only on tag 0xC5.
// - Length byte bounds parsing to the bytes after it.
// - Counts precede individual code and individual string lists.
// - Top bit of each individual entry byte, or of a set's flag byte, is the essential flag.
// - Capability code is the low seven bits of its byte.
// - Codes above 0x6F are followed by a 32-bit format identifier.
// - A format identifier belongs only to the code just before it.
// - String categories 1 to 5 decoded; others reserved.
// - String length byte, then exactly that many body bytes.
// - OR-set count read; set satisfied if any member is supported.
// - Seven-bit code count shares the set's flag byte.
// - After set codes, a count of strings in that set.
// - FEC string split at slash into encoding and instance.
// - Icon descriptor recognised only on tag 0xC6.
// - Icon linkage output as 32 bits, most significant first.
`timescale 1ns/10ps
module cap_desc_parser
(
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    input  wire logic                  in_valid,
    input  wire logic [7:0]            in_byte,
    input  wire logic                  code_supported,
    input  wire logic                  string_supported,
    output logic                       code_valid,
    output logic      [6:0]            code_value,
    output logic                       code_essential,
    output logic                       code_in_set,
    output logic                       code_has_fmt,
    output logic      [31:0]           code_fmt_id,
    output logic                       str_start,
    output cap_desc_pkg::category_t    str_category,
    output logic                       str_essential,
    output logic                       str_in_set,
    output logic                       str_byte_valid,
    output logic      [7:0]            str_byte,
    output logic                       str_after_slash,
    output logic                       str_end,
    output logic                       set_done,
    output logic                       set_satisfied,
    output logic                       set_essential,
    output logic                       icon_valid,
    output logic      [31:0]           icon_linkage,
    output logic                       desc_done,
    output logic                       desc_malformed
);
    import cap_desc_pkg::*;

    typedef enum {
        ST_TAG, ST_LEN, ST_CODE_CNT, ST_CODE, ST_FMT, ST_STR_CNT, ST_CAT, ST_SLEN,
        ST_SBODY, ST_SET_CNT, ST_SET_HDR, ST_SET_STR_CNT, ST_LINK, ST_SKIP, ST_FOREIGN
    } state_t;

    state_t      state_q;
    entry_kind_t phase_q;
    logic [7:0]  left_q;
    logic [7:0]  count_q;
    logic [7:0]  sets_q;
    logic [7:0]  slen_q;
    logic [2:0]  fmt_cnt_q;
    logic [31:0] shift_q;
    logic        is_cap_q;
    logic        is_fec_q;
    logic        bad_q;
    logic        ess_q;
    logic        set_ess_q;
    logic        set_hit_q;
    logic        set_open_q;
    logic        foreign_q;
    logic        done_q;
    logic [6:0]  last_code_q;
    category_t   cat_now;
    logic        load_len;
    logic        take;
    logic        last_byte;
    logic        set_member_hit;

    byte_budget u_budget (
        .ref_clk (ref_clk),
        .reset   (reset),
        .load    (load_len),
        .length  (in_byte),
        .take    (take),
        .left_q  (left_q)
    );

    category_decode u_cat (
        .code     (in_byte[6:0]),
        .category (cat_now)
    );

    assign load_len  = in_valid && state_q == ST_LEN;
    assign take      = in_valid && state_q != ST_TAG && state_q != ST_LEN;
    assign last_byte = take && left_q == 8'h01;

    // Field needs n bytes (including this one); fits if budget allows
    function automatic logic fits(input logic [7:0] left, input logic [8:0] need);
        fits = {1'b0, left} >= need;
    endfunction

    // Next state once a section's list is finished, fixed order
    function automatic state_t after_list(input entry_kind_t ph);
        case (ph)
            ENT_CODE:   after_list = ST_STR_CNT;
            ENT_STRING: after_list = ST_SET_CNT;
            default:    after_list = ST_SKIP;
        endcase
    endfunction

    assign set_member_hit = (code_valid && code_in_set && code_supported)
                          || (str_end && str_in_set && string_supported);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q   <= ST_TAG;
            phase_q   <= ENT_CODE;
            count_q   <= 8'h00;
            sets_q    <= 8'h00;
            slen_q    <= 8'h00;
            fmt_cnt_q <= 3'h0;
            shift_q   <= 32'h0000_0000;
            is_cap_q  <= 1'b0;
            is_fec_q  <= 1'b0;
            bad_q     <= 1'b0;
            ess_q     <= 1'b0;
            set_ess_q <= 1'b0;
            last_code_q <= 7'h00;
            foreign_q   <= 1'b0;
        end else if (in_valid) begin
            case (state_q)
                ST_TAG: begin
                    is_cap_q  <= in_byte == CAP_TAG;
                    foreign_q <= in_byte != CAP_TAG && in_byte != ICON_TAG;
                    bad_q     <= 1'b0;
                    phase_q   <= ENT_CODE;
                    state_q   <= ST_LEN;
                end
                ST_LEN: begin
                    // Unknown tags still need their length loaded to be skipped
                    if (in_byte == 8'h00) begin
                        bad_q   <= !foreign_q;
                        state_q <= ST_TAG;
                    end else if (foreign_q) begin
                        state_q <= ST_FOREIGN;
                    end else begin
                        state_q <= is_cap_q ? ST_CODE_CNT : ST_LINK;
                        fmt_cnt_q <= 3'h0;
                    end
                end
                ST_FOREIGN: state_q <= ST_FOREIGN;
                ST_CODE_CNT, ST_STR_CNT, ST_SET_STR_CNT: begin
                    count_q <= in_byte;
                    if (state_q == ST_STR_CNT) begin
                        phase_q <= ENT_STRING;
                    end
                    if (in_byte == 8'h00) begin
                        state_q <= (state_q == ST_SET_STR_CNT)
                                   ? ((sets_q == 8'h00) ? ST_SKIP : ST_SET_HDR)
                                   : after_list(state_q == ST_CODE_CNT ? ENT_CODE
                                                                       : ENT_STRING);
                    end else begin
                        state_q <= (state_q == ST_CODE_CNT) ? ST_CODE : ST_CAT;
                    end
                end
                ST_CODE: begin
                    ess_q       <= in_byte[FLAG_BIT];
                    last_code_q <= in_byte[6:0];
                    count_q     <= count_q - 8'h01;
                    if (in_byte[6:0] > CODE_FMT_LIMIT) begin
                        fmt_cnt_q <= 3'h0;
                        state_q   <= ST_FMT;
                    end else if (count_q == 8'h01) begin
                        state_q <= (phase_q == ENT_SET) ? ST_SET_STR_CNT : after_list(phase_q);
                    end
                end
                ST_FMT: begin
                    shift_q   <= {shift_q[23:0], in_byte};
                    fmt_cnt_q <= fmt_cnt_q + 3'h1;
                    if (fmt_cnt_q == 3'(FMT_ID_BYTES - 1)) begin
                        if (count_q == 8'h00) begin
                            state_q <= (phase_q == ENT_SET) ? ST_SET_STR_CNT
                                                            : after_list(phase_q);
                        end else begin
                            state_q <= ST_CODE;
                        end
                    end
                end
                ST_CAT: begin
                    ess_q    <= in_byte[FLAG_BIT];
                    is_fec_q <= cat_now == CAT_FEC;
                    count_q  <= count_q - 8'h01;
                    state_q  <= ST_SLEN;
                end
                ST_SLEN: begin
                    slen_q   <= in_byte;
                    shift_q  <= 32'h0000_0000;
                    if (in_byte != 8'h00) begin
                        state_q <= ST_SBODY;
                    end else if (count_q != 8'h00) begin
                        state_q <= ST_CAT;
                    end else begin
                        state_q <= (phase_q == ENT_SET)
                                   ? ((sets_q == 8'h00) ? ST_SKIP : ST_SET_HDR)
                                   : after_list(phase_q);
                    end
                end
                ST_SBODY: begin
                    slen_q <= slen_q - 8'h01;
                    if (in_byte == SLASH_CHAR && is_fec_q) begin
                        shift_q[0] <= 1'b1;
                    end
                    if (slen_q == 8'h01) begin
                        if (count_q != 8'h00) begin
                            state_q <= ST_CAT;
                        end else if (phase_q == ENT_SET) begin
                            state_q <= (sets_q == 8'h00) ? ST_SKIP : ST_SET_HDR;
                        end else begin
                            state_q <= after_list(phase_q);
                        end
                    end
                end
                ST_SET_CNT: begin
                    phase_q <= ENT_SET;
                    sets_q  <= in_byte;
                    state_q <= (in_byte == 8'h00) ? ST_SKIP : ST_SET_HDR;
                end
                ST_SET_HDR: begin
                    set_ess_q <= in_byte[FLAG_BIT];
                    sets_q    <= sets_q - 8'h01;
                    count_q   <= {1'b0, in_byte[6:0]};
                    state_q   <= (in_byte[6:0] == 7'h00) ? ST_SET_STR_CNT : ST_CODE;
                end
                ST_LINK: begin
                    shift_q   <= {shift_q[23:0], in_byte};
                    fmt_cnt_q <= fmt_cnt_q + 3'h1;
                    if (fmt_cnt_q == 3'(LINKAGE_BYTES - 1)) begin
                        state_q <= ST_SKIP;
                    end
                end
                ST_SKIP: state_q <= ST_SKIP;
                default: state_q <= ST_TAG;
            endcase
            // Overrun check: each field must fit in what is left
            if ((state_q == ST_FMT || state_q == ST_LINK)
                && !fits(left_q, 9'(FMT_ID_BYTES - int'(fmt_cnt_q)))) begin
                bad_q <= 1'b1;
            end
            if (state_q == ST_SBODY && !fits(left_q, {1'b0, slen_q})) begin
                bad_q <= 1'b1;
            end
            if (last_byte) begin
                state_q <= ST_TAG;
                if (state_q != ST_SKIP && state_q != ST_FOREIGN && !is_last_ok()) begin
                    bad_q <= 1'b1;
                end
            end
        end
    end

    // Descriptor may end only where no field is half read
    function automatic logic is_last_ok();
        is_last_ok = (state_q == ST_LINK && fmt_cnt_q == 3'(LINKAGE_BYTES - 1))
                  || (state_q == ST_SET_CNT && in_byte == 8'h00)
                  || (state_q == ST_SET_STR_CNT && in_byte == 8'h00 && sets_q == 8'h00)
                  || (state_q == ST_SLEN && in_byte == 8'h00 && count_q == 8'h00
                      && phase_q == ENT_SET && sets_q == 8'h00)
                  || (state_q == ST_SBODY && slen_q == 8'h01 && count_q == 8'h00
                      && phase_q == ENT_SET && sets_q == 8'h00);
    endfunction

    // Event strobes, all registered
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            code_valid <= 1'b0; code_value <= 7'h00; code_essential <= 1'b0;
            code_in_set <= 1'b0; code_has_fmt <= 1'b0; code_fmt_id <= 32'h0000_0000;
            str_start <= 1'b0; str_category <= CAT_RESERVED; str_essential <= 1'b0;
            str_in_set <= 1'b0; str_byte_valid <= 1'b0; str_byte <= 8'h00;
            str_after_slash <= 1'b0; str_end <= 1'b0;
            icon_valid <= 1'b0; icon_linkage <= 32'h0000_0000;
            desc_done <= 1'b0; desc_malformed <= 1'b0;
            done_q <= 1'b0;
        end else begin
            code_valid     <= 1'b0;
            str_start      <= 1'b0;
            str_byte_valid <= 1'b0;
            str_end        <= 1'b0;
            icon_valid     <= 1'b0;
            desc_done      <= done_q;
            if (in_valid && state_q == ST_CODE && in_byte[6:0] <= CODE_FMT_LIMIT) begin
                code_valid     <= 1'b1;
                code_value     <= in_byte[6:0];
                code_essential <= (phase_q == ENT_SET) ? set_ess_q : in_byte[FLAG_BIT];
                code_in_set    <= phase_q == ENT_SET;
                code_has_fmt   <= 1'b0;
            end
            if (in_valid && state_q == ST_FMT && fmt_cnt_q == 3'(FMT_ID_BYTES - 1)) begin
                code_valid     <= 1'b1;
                code_value     <= last_code_q;
                code_essential <= (phase_q == ENT_SET) ? set_ess_q : ess_q;
                code_in_set    <= phase_q == ENT_SET;
                code_has_fmt   <= 1'b1;
                code_fmt_id    <= {shift_q[23:0], in_byte};
            end
            if (in_valid && state_q == ST_SLEN) begin
                str_start       <= 1'b1;
                str_essential   <= (phase_q == ENT_SET) ? set_ess_q : ess_q;
                str_in_set      <= phase_q == ENT_SET;
                str_after_slash <= 1'b0;
                str_end         <= in_byte == 8'h00;
            end
            if (in_valid && state_q == ST_CAT) begin
                str_category <= cat_now;
            end
            if (in_valid && state_q == ST_SBODY) begin
                str_byte_valid  <= 1'b1;
                str_byte        <= in_byte;
                str_after_slash <= is_fec_q && (shift_q[0] || in_byte == SLASH_CHAR);
                str_end         <= slen_q == 8'h01;
            end
            if (in_valid && state_q == ST_LINK && fmt_cnt_q == 3'(LINKAGE_BYTES - 1)) begin
                icon_valid   <= 1'b1;
                icon_linkage <= {shift_q[23:0], in_byte};
            end
            // End marker waits a cycle so the verdict on the last byte is in
            done_q         <= (last_byte && state_q != ST_FOREIGN)
                           || (in_valid && state_q == ST_LEN && !foreign_q && in_byte == 8'h00);
            desc_malformed <= bad_q;
        end
    end

    // Set result: reported the cycle after its last byte, when the answer
    // for its last member is on show
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            set_hit_q     <= 1'b0;
            set_open_q    <= 1'b0;
            set_done      <= 1'b0;
            set_satisfied <= 1'b0;
            set_essential <= 1'b0;
        end else begin
            set_done <= 1'b0;
            if (in_valid && state_q == ST_SET_HDR) begin
                set_hit_q <= 1'b0;
            end else if (set_member_hit) begin
                set_hit_q <= 1'b1;
            end
            if (set_open_q
                && (state_q == ST_SET_HDR || state_q == ST_SKIP || state_q == ST_TAG)) begin
                set_open_q    <= 1'b0;
                set_done      <= 1'b1;
                set_satisfied <= set_hit_q || set_member_hit;
                set_essential <= set_ess_q;
            end
            if (in_valid && state_q == ST_SET_HDR) begin
                set_open_q <= 1'b1;
            end
        end
    end

    chk_tag_gates_len: assert property (@(posedge ref_clk) disable iff (reset)
        (in_valid && state_q == ST_LEN && foreign_q)
        |=> state_q != ST_CODE_CNT && state_q != ST_LINK)
        else $error("Foreign tag entered parsing");
    chk_link_order: assert property (@(posedge ref_clk) disable iff (reset)
        icon_valid |-> icon_linkage[7:0] == $past(in_byte))
        else $error("Icon linkage byte order wrong");
    chk_fmt_follows: assert property (@(posedge ref_clk) disable iff (reset)
        (code_valid && code_has_fmt) |-> code_value > CODE_FMT_LIMIT)
        else $error("Format id on small code");
    chk_zero_len_bad: assert property (@(posedge ref_clk) disable iff (reset)
        (in_valid && state_q == ST_LEN && !foreign_q && in_byte == 8'h00)
        |=> ##1 desc_done && desc_malformed)
        else $error("Empty descriptor not flagged");
    chk_str_end_pair: assert property (@(posedge ref_clk) disable iff (reset)
        str_end |-> str_byte_valid || str_start)
        else $error("String end without body or start");
    chk_done_single: assert property (@(posedge ref_clk) disable iff (reset)
        desc_done |=> !desc_done)
        else $error("Descriptor end held too long");
endmodule

//--- src/cap_desc_pkg.sv
/*
 Constants for the capability and icon descriptor parser.
 Assumes a byte stream of whole descriptors, tag byte first.
*/
package cap_desc_pkg;
    localparam logic [7:0] CAP_TAG        = 8'hC5;
    localparam logic [7:0] ICON_TAG       = 8'hC6;
    localparam logic [6:0] CODE_FMT_LIMIT = 7'h6F;
    localparam int         FMT_ID_BYTES   = 4;
    localparam int         LINKAGE_BYTES  = 4;
    localparam logic [7:0] SLASH_CHAR     = 8'h2F;
    localparam int         FLAG_BIT       = 7;

    typedef enum logic [2:0] {
        CAT_RESERVED,
        CAT_DOWNLOAD,
        CAT_FEC,
        CAT_WRAPPER,
        CAT_COMPRESSION,
        CAT_MEDIA
    } category_t;

    typedef enum logic [1:0] {
        ENT_CODE,
        ENT_STRING,
        ENT_SET
    } entry_kind_t;
endpackage

//--- src/category_decode.sv
/*
 Maps a 7-bit string category code to the category enumeration.
 Purely combinational; fed from the parser's byte path.
*/
`timescale 1ns/10ps
module category_decode
(
    input  wire logic [6:0]            code,
    output cap_desc_pkg::category_t    category
);
    import cap_desc_pkg::*;

    always_comb begin
        case (code)
            7'h01:   category = CAT_DOWNLOAD;
            7'h02:   category = CAT_FEC;
            7'h03:   category = CAT_WRAPPER;
            7'h04:   category = CAT_COMPRESSION;
            7'h05:   category = CAT_MEDIA;
            default: category = CAT_RESERVED;
        endcase
    end
endmodule

//--- src/byte_budget.sv
/*
 Tracks descriptor bytes left after the length byte.
 Assumes load and take are never asserted together.
*/
`timescale 1ns/10ps
module byte_budget (
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    input  wire logic                  load,
    input  wire logic [7:0]            length,
    input  wire logic                  take,
    output logic      [7:0]            left_q
);
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            left_q <= 8'h00;
        end else if (load) begin
            left_q <= length;
        end else if (take && left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end
endmodule

//--- sim/section_feeder.sv
/*
 Upstream section feeder model: plays one descriptor image as bytes.
 Assumes the bench sets data and count before it pulses go.
*/
`timescale 1ns/10ps
module section_feeder (
    input  wire logic         ref_clk,
    input  wire logic         go,
    input  wire logic         slow,
    input  wire logic [191:0] data,
    input  wire logic [7:0]   count,
    output logic              in_valid,
    output logic [7:0]        in_byte,
    output logic              busy
);
    initial begin
        in_valid = 1'b0;
        in_byte  = 8'h00;
        busy     = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (go) begin
                busy = 1'b1;
                for (int i = 0; i < count; i++) begin
                    #1;
                    in_valid = 1'b1;
                    in_byte  = data[8*(count-1-i) +: 8];
                    @(posedge ref_clk);
                    if (slow) begin
                        #1;
                        in_valid = 1'b0;
                        in_byte  = ~in_byte;
                        @(posedge ref_clk);
                    end
                end
                #1;
                in_valid = 1'b0;
                // Idle byte lines flip the value on show; after a slow gap this restores the last byte
                in_byte  = ~in_byte;
                busy     = 1'b0;
            end
        end
    end
endmodule

//--- sim/cap_desc_parser_tb_top.sv
/*
 Self-checking bench for the descriptor parser: table of descriptors.
 Assumes the feeder model plays bytes; matcher answers are modelled here.
*/
`timescale 1ns/10ps
module cap_desc_parser_tb_top;
    import cap_desc_pkg::*;
    typedef struct {
        logic [191:0] b;
        int n; logic [6:0] sup; int ss, codes, ess, fmts; logic [31:0] fmt;
        int sb, sl, sets, sat, catm, icons; logic [31:0] lnk; int dn, mal;
    } row_t;
    logic ref_clk, reset, go, slow, in_valid, busy, ss;
    logic [7:0] in_byte, count;
    logic [191:0] data;
    logic [6:0] sup, code_value;
    logic code_valid, code_essential, code_in_set, code_has_fmt, str_start, str_essential;
    logic str_in_set, str_byte_valid, str_after_slash, str_end, set_done, set_satisfied;
    logic set_essential, icon_valid, desc_done, desc_malformed;
    logic [31:0] code_fmt_id, icon_linkage, c_fmt, c_lnk;
    logic [7:0] str_byte;
    category_t str_category;
    int c_codes, c_ess, c_fmts, c_sb, c_sl, c_sets, c_sat, c_catm, c_icons, c_dn, c_mal;
    int bad_count, n_checks;
    row_t rows [9];
    row_t bb;
    // Code matcher answers combinationally from the code on show; string answer is fixed per row
    wire code_supported   = (code_value === sup);
    wire string_supported = ss;

    section_feeder section_feeder_inst (.ref_clk(ref_clk), .go(go), .slow(slow),
        .data(data), .count(count), .in_valid(in_valid), .in_byte(in_byte), .busy(busy));
    cap_desc_parser cap_desc_parser_inst (.ref_clk(ref_clk), .reset(reset),
        .in_valid(in_valid), .in_byte(in_byte), .code_supported(code_supported),
        .string_supported(string_supported), .code_valid(code_valid),
        .code_value(code_value), .code_essential(code_essential), .code_in_set(code_in_set),
        .code_has_fmt(code_has_fmt), .code_fmt_id(code_fmt_id), .str_start(str_start),
        .str_category(str_category), .str_essential(str_essential), .str_in_set(str_in_set),
        .str_byte_valid(str_byte_valid), .str_byte(str_byte),
        .str_after_slash(str_after_slash), .str_end(str_end), .set_done(set_done),
        .set_satisfied(set_satisfied), .set_essential(set_essential),
        .icon_valid(icon_valid), .icon_linkage(icon_linkage), .desc_done(desc_done),
        .desc_malformed(desc_malformed));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Outputs are registered, so sampling on the edge sees settled values
    always @(posedge ref_clk) begin
        if (code_valid === 1'b1) begin
            c_codes++;
            if (code_essential === 1'b1 && code_in_set === 1'b0) c_ess++;
            if (code_has_fmt === 1'b1) begin
                c_fmts++;
                c_fmt = code_fmt_id;
            end
        end
        if (str_byte_valid === 1'b1) c_sb++;
        if (str_byte_valid === 1'b1 && str_after_slash === 1'b1) c_sl++;
        if (str_end === 1'b1) c_catm = c_catm | (1 << int'(str_category));
        if (str_start === 1'b1 && str_essential === 1'b1) c_ess++;
        if (set_done === 1'b1) begin
            c_sets++;
            c_sat = set_satisfied;
        end
        if (icon_valid === 1'b1) begin
            c_icons++;
            c_lnk = icon_linkage;
        end
        if (desc_done === 1'b1) begin
            c_dn++;
            c_mal = desc_malformed;
        end
    end

    task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic feed(input row_t r, input logic s);
        data = r.b;
        count = r.n[7:0];
        slow = s;
        ss = r.ss[0];
        sup = r.sup;
        {c_codes, c_ess, c_fmts, c_sb, c_sl, c_sets, c_sat, c_catm, c_icons, c_dn} = '0;
        c_mal = 0;
        go = 1'b1;
        @(posedge ref_clk);
        #1 go = 1'b0;
        for (int k = 0; k < 60 && busy !== 1'b0; k++) @(posedge ref_clk);
        chkv(busy, 32'h0);
        #1;
    endtask

    task automatic run(input row_t r, input logic s);
        feed(r, s);
        repeat (4) @(posedge ref_clk);
        #1;
        if (r.mal == 0) begin
            chkv(c_codes, r.codes);
            chkv(c_ess, r.ess);
            chkv(c_fmts, r.fmts);
            if (r.fmts > 0) chkv(c_fmt, r.fmt);
            chkv(c_sb, r.sb);
            chkv(c_sl, r.sl);
            chkv(c_catm, r.catm);
            chkv(c_sets, r.sets);
            if (r.sets > 0) chkv(c_sat, r.sat);
        end
        chkv(c_icons, r.icons);
        if (r.icons > 0) chkv(c_lnk, r.lnk);
        chkv(c_dn, r.dn);
        chkv(c_mal, r.mal);
    endtask

    initial begin
        #200000;
        bad_count++;
        results();
    end

    initial begin
        reset = 1'b1;
        go = 1'b0;
        slow = 1'b0;
        ss = 1'b0;
        sup = 7'h00;
        data = '0;
        count = 8'h00;
        rows[0] = '{192'hC6051122334400, 7, 7'h00, 0, 0, 0, 0, 32'h0, 0, 0, 0, 0, 0, 1,
            32'h11223344, 1, 0};
        rows[1] = '{192'hC702AABB, 4, 7'h00, 0, 0, 0, 0, 32'h0, 0, 0, 0, 0, 0, 0, 32'h0, 0, 0};
        rows[2] = '{192'hC5110285F001020304018203352F3201816F00, 19, 7'h6F, 0, 3, 3, 1,
            32'h01020304, 3, 2, 1, 1, 4, 0, 32'h0, 1, 0};
        rows[3] = '{192'hC5080000010001050161, 10, 7'h00, 1, 0, 0, 0, 32'h0, 1, 0, 1, 1, 32,
            0, 32'h0, 1, 0};
        rows[4] = '{192'hC50F000601000200030004000500060000, 17, 7'h00, 0, 0, 0, 0, 32'h0,
            0, 0, 0, 0, 63, 0, 32'h0, 1, 0};
        rows[5] = '{192'hC5050000018000, 7, 7'h00, 0, 0, 0, 0, 32'h0, 0, 0, 1, 0, 0, 0,
            32'h0, 1, 0};
        rows[6] = '{192'hC50301F001, 5, 7'h00, 0, 0, 0, 0, 32'h0, 0, 0, 0, 0, 0, 0, 32'h0, 1, 1};
        rows[7] = '{192'hC500, 2, 7'h00, 0, 0, 0, 0, 32'h0, 0, 0, 0, 0, 0, 0, 32'h0, 1, 1};
        rows[8] = '{192'hC603112233, 5, 7'h00, 0, 0, 0, 0, 32'h0, 0, 0, 0, 0, 0, 0, 32'h0, 1, 1};
        repeat (5) @(posedge ref_clk);
        #1 reset = 1'b0;
        chkv({code_valid, icon_valid, desc_done, desc_malformed, code_value}, 32'h0);
        // Each row once at full rate, once with idle gaps between bytes
        for (int i = 0; i < 18; i++) run(rows[i % 9], i >= 9);
        // Two descriptors back to back: the length byte alone separates them
        bb = rows[0];
        bb.b = {56'hC6051122334400, 48'hC604A1B2C3D4};
        bb.n = 13;
        bb.icons = 2;
        bb.lnk = 32'hA1B2C3D4;
        bb.dn = 2;
        run(bb, 1'b0);
        // Reset held across a descriptor in flight clears code_valid, str_byte_valid, set_done, desc_done and desc_malformed
        data = rows[2].b;
        count = 8'd19;
        go = 1'b1;
        @(posedge ref_clk);
        #1 go = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1 reset = 1'b1;
        for (int k = 0; k < 60 && busy !== 1'b0; k++) @(posedge ref_clk);
        chkv(busy, 32'h0);
        @(posedge ref_clk);
        #1;
        chkv({code_valid, str_byte_valid, set_done, desc_done, desc_malformed}, 32'h0);
        reset = 1'b0;
        run(rows[0], 1'b0);
        results();
    end
endmodule
